// file: hdl/cma_consts.svh
// constants for the cpu memory address resolver
// assumes inclusion by bare name from hdl files only
`ifndef CMA_CONSTS_SVH
`define CMA_CONSTS_SVH

`define CMA_RESET_PC        16'h0000
`define CMA_SP_RESET        8'h07
`define CMA_VEC_BASE        16'h0003
`define CMA_VEC_SHIFT       3
`define CMA_CODE_SIZE       16384
`define CMA_CODE_MASK       16'h3FFF
`define CMA_EXPANDED_RAM_SIZE       768
`define CMA_EXPANDED_RAM_LAST       16'h02FF
`define CMA_LOWER_TOP       8'h7F
`define CMA_BITRAM_BASE     8'h20
`define CMA_BANK_POS        3
`define CMA_PAGE_W          2
`define CMA_MAX_CYCLES      3'd6
`define CMA_MIN_CYCLES      3'd1

`endif

// file: hdl/cma_pkg.sv
// types for the cpu memory address resolver
// assumes cma_consts.svh defines the numeric constants
package cma_pkg;

  // operand addressing modes requested by the core
  typedef enum logic [3:0] {
    CMA_DIRECT      = 4'h0,
    CMA_INDIRECT    = 4'h1,
    CMA_REGISTER    = 4'h2,
    CMA_IMMEDIATE   = 4'h3,
    CMA_INDEX_DATA_POINTER  = 4'h4,
    CMA_INDEX_PC    = 4'h5,
    CMA_JUMP_INDEX  = 4'h6,
    CMA_STACK_PUSH  = 4'h7,
    CMA_XMOV_PTR16  = 4'h8,
    CMA_XMOV_PTR8   = 4'h9,
    CMA_BIT         = 4'hA,
    CMA_INTERRUPT   = 4'hB,
    CMA_NONE        = 4'hF
  } cma_mode_t;

  // target memory space of a resolved address
  typedef enum logic [2:0] {
    CMA_SP_IRAM   = 3'h0,
    CMA_SP_UPPER  = 3'h1,
    CMA_SP_SFR    = 3'h2,
    CMA_SP_CODE   = 3'h3,
    CMA_SP_EXPANDED_RAM   = 3'h4,
    CMA_SP_NONE   = 3'h7
  } cma_space_t;

  // instruction sequencing states, one bit flips from idle to exec and from exec to last
  typedef enum logic [1:0] {
    CMA_ST_IDLE = 2'b00,
    CMA_ST_EXEC = 2'b01,
    CMA_ST_LAST = 2'b11
  } cma_state_t;

endpackage : cma_pkg

// file: hdl/cma_expanded_ram.sv
// expanded ram store shared by paged and 16-bit external moves
// assumes single clock, synchronous active-low reset in the parent
`timescale 1ns/10ps
`default_nettype none
`include "cma_consts.svh"

module cma_expanded_ram #(
  parameter int DEPTH = `CMA_EXPANDED_RAM_SIZE
) (
  input  wire logic        clk_i,     // system clock
  input  wire logic        we_i,      // write strobe
  input  wire logic        re_i,      // read strobe
  input  wire logic [15:0] addr_i,    // byte address
  input  wire logic [7:0]  wdata_i,   // write byte
  output logic      [7:0]  rdata_o    // registered read byte
);

  logic [7:0] mem [DEPTH];
  logic       in_range;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // out-of-range writes dropped, reads give zero
  assign in_range = (addr_i < 16'(DEPTH));                          // RULE23

  // one array serves both pointer forms
  always_ff @(posedge clk_i) begin
    if (we_i && in_range) begin                                     // RULE19
      mem[addr_i[9:0]] <= wdata_i;
    end
  end

  // read path next value
  always_comb begin
    rdata_next = rdata_reg;
    if (re_i) begin
      rdata_next = in_range ? mem[addr_i[9:0]] : 8'h00;             // RULE23
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_reg <= rdata_next;
  end

  assign rdata_o = rdata_reg;

endmodule : cma_expanded_ram
`default_nettype wire

// file: hdl/cma_resolver.sv
// cpu operand and fetch address resolver with expanded ram
// assumes the core supplies mode, fields and pointers on the same clock
//
// Contract
// RULE1: each instruction finishes in one to six clocks, count from encoding.
// RULE2: timing counted in plain clocks, no machine cycles.
// RULE3: direct mode uses 8-bit field, reaches only internal ram and sfrs.
// RULE4: indirect 8-bit uses r0, r1 or stack pointer; 16-bit uses data pointer.
// RULE5: register form picks one of eight registers by 3-bit field.
// RULE6: immediate constant read from code bytes after the opcode.
// RULE7: indexed reads only code memory at base plus accumulator.
// RULE8: indexed jump target equals base pointer plus accumulator.
// RULE9: code memory read-only, 16k on-chip, no off-chip fetch.
// RULE10: fetch starts at address 0000H after reset.
// RULE11: interrupt vectors at 0003H plus 8 bytes per source.
// RULE12: above 7FH direct selects sfrs, indirect selects upper ram.
// RULE13: lowest 32 bytes are four banks of eight registers.
// RULE14: 16 bytes above banks are bit-addressable as bits 00H to 7FH.
// RULE15: lower 128 bytes direct or indirect; upper 128 indirect only.
// RULE16: sfrs only direct; bit access only at addresses ending 0H or 8H.
// RULE17: 768-byte expanded ram reached only by external move.
// RULE18: no off-chip data memory; external moves hit expanded ram.
// RULE19: paged and 16-bit spaces share one physical array.
// RULE20: bank select bits choose the working register bank.
// RULE21: page select supplies the high byte for 8-bit external moves.
// RULE22: stack pointer increments before each push writes.
// RULE23: out-of-range expanded ram writes ignored, reads return zero.
`timescale 1ns/10ps
`default_nettype none
`include "cma_consts.svh"

module cma_resolver
  import cma_pkg::*;
#(
  parameter int CODE_SIZE = `CMA_CODE_SIZE,
  parameter int EXPANDED_RAM_SIZE = `CMA_EXPANDED_RAM_SIZE
) (
  input  wire logic                   clk_i,        // system clock
  input  wire logic                   rst_n_i,      // sync reset, active low
  input  wire logic                   req_i,        // address request strobe
  input  wire cma_pkg::cma_mode_t     mode_i,       // addressing mode
  input  wire logic [7:0]             field_i,      // direct/bit field
  input  wire logic [2:0]             reg_sel_i,    // register number
  input  wire logic                   ptr_sel_i,    // 0 r0, 1 r1 for indirect and paged moves
  input  wire logic [7:0]             r0_i,         // working register 0
  input  wire logic [7:0]             r1_i,         // working register 1
  input  wire logic [7:0]             status_word_i, // status word
  input  wire logic [15:0]            data_pointer_i, // data pointer
  input  wire logic [7:0]             acc_i,        // accumulator
  input  wire logic [15:0]            pc_i,         // program counter
  input  wire logic [1:0]             expanded_page_select_i, // page select
  input  wire logic [3:0]             irq_src_i,    // interrupt source number
  input  wire logic                   wr_i,         // write for external move
  input  wire logic [7:0]             wdata_i,      // external move data
  input  wire logic [2:0]             cycles_i,     // clocks of current insn
  input  wire logic                   insn_start_i, // first clock of insn
  output logic      [15:0]            addr_o,       // resolved address
  output cma_pkg::cma_space_t         space_o,      // target space
  output logic      [2:0]             bit_pos_o,    // bit in byte
  output logic                        valid_o,      // address valid pulse
  output logic                        illegal_o,    // refused access pulse
  output logic      [7:0]             stack_pointer_o, // stack pointer
  output logic      [15:0]            fetch_addr_o, // next fetch address
  output logic      [7:0]             xdata_o,      // expanded ram read byte
  output logic                        insn_done_o   // instruction end pulse
);

  import cma_pkg::*;

  // ==================================================================
  // registers
  // every top output below is a flop; the core sees settled values
  // one clock after it raises its strobe, never the raw decode.
  // trade-off: one clock of latency on every address, in exchange
  // for a clean timing path from decode into the memory arrays.
  logic [15:0] addr_reg,  addr_next;
  cma_space_t  space_reg, space_next;
  logic [2:0]  bit_reg,   bit_next;
  logic        valid_reg, valid_next;
  logic        ill_reg,   ill_next;
  logic [7:0]  sp_reg,    sp_next;
  logic [15:0] fetch_reg, fetch_next;
  logic        x_we, x_re;
  logic [15:0] x_addr;
  logic [1:0]  bank;
  logic [15:0] idx_sum;
  logic [7:0]  ind8;

  // ==================================================================
  // shared terms
  assign bank    = {status_word_i[4], status_word_i[3]};        // RULE20
  // carry out of bit 15 dropped on purpose: table walks wrap
  assign idx_sum = 16'(((mode_i == CMA_INDEX_PC) ? pc_i : data_pointer_i)
                   + {8'h00, acc_i});                            // RULE7 RULE8
  assign ind8    = ptr_sel_i ? r1_i : r0_i;                      // RULE4

  // address decode per mode
  // notes for the next reader:
  // - direct and indirect share the 80H..FFH block but land in
  //   different spaces; the space code tells them apart downstream
  // - register form never leaves the lowest 32 bytes
  // - bit mode with bit 7 clear maps into the 16-byte bit area,
  //   with bit 7 set it names a bit-addressable sfr (low nibble 0 or 8)
  // - code addresses are cut to the on-chip size; nothing reaches
  //   past it, since there is no off-chip program store
  // - external moves only ever reach the expanded ram
  // - an unknown mode answers with a refused pulse, no valid pulse
  always_comb begin
    addr_next  = addr_reg;
    space_next = space_reg;
    bit_next   = 3'd0;
    valid_next = 1'b0;
    ill_next   = 1'b0;
    sp_next    = sp_reg;
    fetch_next = fetch_reg;
    x_we       = 1'b0;
    x_re       = 1'b0;
    x_addr     = 16'h0000;
    if (req_i) begin
      valid_next = 1'b1;
      case (mode_i)
        CMA_DIRECT: begin
          addr_next  = {8'h00, field_i};                          // RULE3
          space_next = (field_i > `CMA_LOWER_TOP) ? CMA_SP_SFR
                                                  : CMA_SP_IRAM;  // RULE12 RULE15
        end
        CMA_INDIRECT: begin
          addr_next  = {8'h00, ind8};                             // RULE4
          space_next = (ind8 > `CMA_LOWER_TOP) ? CMA_SP_UPPER
                                               : CMA_SP_IRAM;     // RULE12 RULE15
        end
        CMA_REGISTER: begin
          addr_next  = {8'h00, 3'b000, bank, reg_sel_i};          // RULE5 RULE13
          space_next = CMA_SP_IRAM;
        end
        CMA_IMMEDIATE: begin
          addr_next  = 16'(pc_i + 16'h0001) & `CMA_CODE_MASK;     // RULE6
          space_next = CMA_SP_CODE;
        end
        CMA_INDEX_DATA_POINTER, CMA_INDEX_PC: begin
          addr_next  = idx_sum & `CMA_CODE_MASK;                  // RULE7 RULE9
          space_next = CMA_SP_CODE;
        end
        CMA_JUMP_INDEX: begin
          addr_next  = idx_sum & `CMA_CODE_MASK;                  // RULE8
          fetch_next = idx_sum & `CMA_CODE_MASK;
          space_next = CMA_SP_CODE;
        end
        CMA_STACK_PUSH: begin
          sp_next    = 8'(sp_reg + 8'h01);                        // RULE22
          addr_next  = {8'h00, 8'(sp_reg + 8'h01)};
          space_next = (8'(sp_reg + 8'h01) > `CMA_LOWER_TOP) ? CMA_SP_UPPER
                                                             : CMA_SP_IRAM;
        end
        CMA_XMOV_PTR16: begin
          x_addr     = data_pointer_i;                            // RULE17 RULE18
          addr_next  = data_pointer_i;
          space_next = CMA_SP_EXPANDED_RAM;
          x_we       = wr_i;
          x_re       = !wr_i;
        end
        CMA_XMOV_PTR8: begin
          x_addr     = {6'h00, expanded_page_select_i, ind8};     // RULE21 RULE19
          addr_next  = {6'h00, expanded_page_select_i, ind8};
          space_next = CMA_SP_EXPANDED_RAM;
          x_we       = wr_i;
          x_re       = !wr_i;
        end
        CMA_BIT: begin
          bit_next = field_i[2:0];
          if (!field_i[7]) begin
            addr_next  = {8'h00, 8'(`CMA_BITRAM_BASE + {4'h0, field_i[6:3]})}; // RULE14
            space_next = CMA_SP_IRAM;
          end else begin
            addr_next  = {8'h00, field_i[7:3], 3'b000};           // RULE16
            space_next = CMA_SP_SFR;
          end
        end
        CMA_INTERRUPT: begin
          fetch_next = `CMA_VEC_BASE
                       + {9'h000, irq_src_i, 3'b000};             // RULE11
          addr_next  = fetch_next;
          space_next = CMA_SP_CODE;
        end
        default: begin
          valid_next = 1'b0;
          ill_next   = 1'b1;                                      // RULE9
          space_next = CMA_SP_NONE;
        end
      endcase
    end
  end

  // decode registers; reset parks the fetch address at the start of code
  // limitation: stack pointer is only moved by pushes seen here, a pop
  // or a software write to it is outside this block
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_reg  <= 16'h0000;
      space_reg <= CMA_SP_NONE;
      bit_reg   <= 3'd0;
      valid_reg <= 1'b0;
      ill_reg   <= 1'b0;
      sp_reg    <= `CMA_SP_RESET;
      fetch_reg <= `CMA_RESET_PC;                                  // RULE10
    end else begin
      addr_reg  <= addr_next;
      space_reg <= space_next;
      bit_reg   <= bit_next;
      valid_reg <= valid_next;
      ill_reg   <= ill_next;
      sp_reg    <= sp_next;
      fetch_reg <= fetch_next;
    end
  end

  // ==================================================================
  // instruction cycle counter, plain clocks with no machine-cycle grouping
  cma_state_t st_reg, st_next;
  logic [2:0] cnt_reg, cnt_next;
  logic       done_reg, done_next;
  logic [2:0] len;

  // clamp length into the legal 1..6 window
  // a bad length from the core is forced into range rather than
  // hanging the sequencer; the core must still encode it correctly
  assign len = (cycles_i < `CMA_MIN_CYCLES) ? `CMA_MIN_CYCLES :
               (cycles_i > `CMA_MAX_CYCLES) ? `CMA_MAX_CYCLES : cycles_i; // RULE1

  // sequencer next state; a start while busy is ignored
  // a length of two skips straight to the last state
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    case (st_reg)
      CMA_ST_IDLE: begin
        if (insn_start_i) begin
          if (len == 3'd1) begin
            done_next = 1'b1;                                     // RULE2
          end else begin
            cnt_next = 3'(len - 3'd2);
            st_next  = (len == 3'd2) ? CMA_ST_LAST : CMA_ST_EXEC;
          end
        end
      end
      CMA_ST_EXEC: begin
        cnt_next = 3'(cnt_reg - 3'd1);
        if (cnt_reg == 3'd1) begin
          st_next = CMA_ST_LAST;
        end
      end
      CMA_ST_LAST: begin
        done_next = 1'b1;                                         // RULE1
        st_next   = CMA_ST_IDLE;
      end
      default: begin
        st_next = CMA_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg   <= CMA_ST_IDLE;
      cnt_reg  <= 3'd0;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  // ==================================================================
  // expanded ram, registered read data
  // both pointer forms reach this one array, so a paged write is seen
  // by a 16-bit read of the same byte; reads answer one clock later
  cma_expanded_ram #(
    .DEPTH   (EXPANDED_RAM_SIZE)
  ) u_expanded_ram (
    .clk_i   (clk_i),
    .we_i    (x_we),
    .re_i    (x_re),
    .addr_i  (x_addr),
    .wdata_i (wdata_i),
    .rdata_o (xdata_o)
  );

  // outputs straight from the flops above
  assign addr_o          = addr_reg;
  assign space_o         = space_reg;
  assign bit_pos_o       = bit_reg;
  assign valid_o         = valid_reg;
  assign illegal_o       = ill_reg;
  assign stack_pointer_o = sp_reg;
  assign fetch_addr_o    = fetch_reg;
  assign insn_done_o     = done_reg;

endmodule : cma_resolver
`default_nettype wire

// file: verification/cma_chk_sva.sv
// checker watching the address resolver ports
// assumes cma_pkg is compiled first; one clock domain
`timescale 1ns/10ps
`default_nettype none

// ====================================
// checker
module cma_chk
  import cma_pkg::*;
(
  input wire logic        clk_i,           // clock
  input wire logic        rst_n_i,         // reset
  input wire logic        req_i,           // strobe
  input wire cma_mode_t   mode_i,          // mode
  input wire logic [7:0]  field_i,         // field
  input wire logic [2:0]  reg_sel_i,       // reg no
  input wire logic [7:0]  status_word_i,   // bank
  input wire logic [15:0] data_pointer_i,  // base
  input wire logic [7:0]  acc_i,           // index
  input wire logic [3:0]  irq_src_i,       // source
  input wire logic [15:0] addr_o,          // address
  input wire cma_space_t  space_o,         // space
  input wire logic        valid_o,         // valid
  input wire logic        illegal_o,       // refused
  input wire logic [7:0]  stack_pointer_o, // sp
  input wire logic [15:0] fetch_addr_o,    // fetch
  input wire logic        insn_done_o      // done
);
  // bank bits as a signal so $past sees a plain name
  wire logic [1:0] bank = status_word_i[4:3];

  // all checks share the clock and the reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_REQ_ANSWER:
    assert property (req_i |=> valid_o != illegal_o) else $error("no single answer");
  AST_DIRECT_SPACE:
    assert property (req_i && mode_i == CMA_DIRECT |=> addr_o == {8'h00, $past(field_i)}
      && space_o == ($past(field_i) > 8'h7F ? CMA_SP_SFR : CMA_SP_IRAM)) else $error("bad direct");
  AST_BANK_REG:
    assert property (req_i && mode_i == CMA_REGISTER |=>
      addr_o == {11'h000, $past(bank), $past(reg_sel_i)}) else $error("bad register");
  AST_INDEX_CODE:
    assert property (req_i && mode_i == CMA_INDEX_DATA_POINTER |=> space_o == CMA_SP_CODE
      && addr_o == (($past(data_pointer_i) + {8'h00, $past(acc_i)}) & 16'h3FFF)) else $error("bad index");
  AST_VECTOR:
    assert property (req_i && mode_i == CMA_INTERRUPT |=>
      fetch_addr_o == 16'h0003 + {9'h000, $past(irq_src_i), 3'h0}) else $error("bad vector");
  AST_PUSH_SP:
    assert property (req_i && mode_i == CMA_STACK_PUSH |=> stack_pointer_o ==
      $past(stack_pointer_o) + 8'h01 && addr_o == {8'h00, stack_pointer_o}) else $error("bad push");
  AST_DONE_PULSE:
    assert property (insn_done_o |=> !insn_done_o) else $error("done too long");
  AST_RESET_FETCH:
    assert property ($rose(rst_n_i) |-> fetch_addr_o == 16'h0000) else $error("bad fetch start");

  COV_XMOV8: cover property (req_i && mode_i == CMA_XMOV_PTR8);
  COV_PUSH: cover property (req_i && mode_i == CMA_STACK_PUSH);
  COV_DONE: cover property (insn_done_o);
endmodule : cma_chk

bind cma_resolver cma_chk u_chk (.clk_i, .rst_n_i, .req_i, .mode_i, .field_i, .reg_sel_i,
  .status_word_i, .data_pointer_i, .acc_i, .irq_src_i, .addr_o, .space_o, .valid_o,
  .illegal_o, .stack_pointer_o, .fetch_addr_o, .insn_done_o);

`default_nettype wire

// file: verification/cma_core_model.sv
// core-side model: pointer registers and request strobe
// assumes one caller process drives its tasks
`timescale 1ns/10ps
`default_nettype none

// ====================================
// core model
module cma_core_model
  import cma_pkg::*;
(
  input  wire logic  clk_i,     // clock
  output logic       req_o,     // strobe
  output cma_mode_t  mode_o,    // mode
  output logic [7:0] field_o,   // field
  output logic [2:0] reg_sel_o, // reg no
  output logic       ptr_sel_o, // r0 or r1
  output logic [7:0] r0_o,      // r0
  output logic [7:0] r1_o,      // r1
  output logic [7:0] sw_o,      // status word
  output logic [15:0] dp_o,     // data pointer
  output logic [7:0] acc_o,     // accumulator
  output logic [15:0] pc_o,     // program counter
  output logic [1:0] page_o,    // page select
  output logic [3:0] irq_o,     // source
  output logic       wr_o,      // write
  output logic [7:0] wdata_o    // write byte
);
  // quiet core at time zero
  initial begin
    {req_o, field_o, reg_sel_o, ptr_sel_o, r0_o, r1_o, sw_o, dp_o} = '0;
    {acc_o, pc_o, page_o, irq_o, wr_o, wdata_o} = '0;
    mode_o = CMA_NONE;
  end

  // load pointers on an edge
  task automatic ptrs(input logic [7:0] r0, r1, sw, ac, input logic [15:0] dp, pc,
                      input logic [1:0] pg, input logic [3:0] irq);
    @(posedge clk_i);
    {r0_o, r1_o, sw_o, acc_o, dp_o, pc_o, page_o, irq_o} <= {r0, r1, sw, ac, dp, pc, pg, irq};
  endtask : ptrs

  // one-cycle request; data is inverted once released, never left stale
  task automatic issue(input cma_mode_t m, input logic [7:0] f = 8'h00,
                       input logic [2:0] rs = 3'h0, input logic ps = 1'b0, w = 1'b0,
                       input logic [7:0] wd = 8'h00);
    @(posedge clk_i);
    mode_o <= m;
    {req_o, field_o, reg_sel_o, ptr_sel_o, wr_o, wdata_o} <= {1'b1, f, rs, ps, w, wd};
    @(posedge clk_i);
    {req_o, wr_o, wdata_o} <= {1'b0, 1'b0, ~wd};
    #1;
  endtask : issue
endmodule : cma_core_model

`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the address resolver
// assumes design, checker and core model compiled first
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("unexpected at %0t got %h exp %h", $time, got, exp); \
    end \
  end

// ====================================
// bench top
module testbench;
  import cma_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             start = 1'b0;
  logic [2:0]       cycles = 3'h0;
  wire logic        req, ptr_sel, wr, valid, illegal, done;
  wire cma_mode_t   mode;
  wire cma_space_t  space;
  wire logic [1:0]  page;
  wire logic [2:0]  reg_sel, bit_pos;
  wire logic [3:0]  irq;
  wire logic [7:0]  field, r0, r1, sw, acc, wdata, sp, xdata;
  wire logic [15:0] dp, pc, addr, fetch;
  int               n_errors = 0;
  int               num_checks = 0;
  int               ticks = 0;

  // 4 ns clock
  always #2 clk_i = ~clk_i;

  cma_core_model core (.clk_i(clk_i), .req_o(req), .mode_o(mode), .field_o(field),
    .reg_sel_o(reg_sel), .ptr_sel_o(ptr_sel), .r0_o(r0), .r1_o(r1), .sw_o(sw), .dp_o(dp),
    .acc_o(acc), .pc_o(pc), .page_o(page), .irq_o(irq), .wr_o(wr), .wdata_o(wdata));
  cma_resolver dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .mode_i(mode),
    .field_i(field), .reg_sel_i(reg_sel), .ptr_sel_i(ptr_sel), .r0_i(r0), .r1_i(r1),
    .status_word_i(sw), .data_pointer_i(dp), .acc_i(acc), .pc_i(pc),
    .expanded_page_select_i(page), .irq_src_i(irq), .wr_i(wr), .wdata_i(wdata),
    .cycles_i(cycles), .insn_start_i(start), .addr_o(addr), .space_o(space),
    .bit_pos_o(bit_pos), .valid_o(valid), .illegal_o(illegal), .stack_pointer_o(sp),
    .fetch_addr_o(fetch), .xdata_o(xdata), .insn_done_o(done));

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // hang guard, far above the hundred or so clocks needed
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == 2000) begin
      n_errors++;
      final_report();
    end
  end

  // one request, then judge strobe, address and space
  task automatic op(input cma_mode_t m, input logic [15:0] ea, input cma_space_t es,
                    input logic [7:0] f = 8'h00, input logic [2:0] rs = 3'h0,
                    input logic ps = 1'b0, w = 1'b0, input logic [7:0] wd = 8'h00);
    core.issue(m, f, rs, ps, w, wd);
    `CHK(valid, 1'b1)
    `CHK(addr, ea)
    `CHK(space, es)
  endtask : op

  task automatic t_reset_push();
    `CHK(fetch, 16'h0000)
    `CHK(sp, 8'h07)
    op(CMA_STACK_PUSH, 16'h0008, CMA_SP_IRAM);
    op(CMA_STACK_PUSH, 16'h0009, CMA_SP_IRAM);
    `CHK(sp, 8'h09)
  endtask : t_reset_push

  // both sides of the 7FH split, then a bit-area bit and an sfr bit
  task automatic t_data();
    core.ptrs(8'h90, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, 2'h0, 4'h0);
    op(CMA_DIRECT, 16'h007F, CMA_SP_IRAM, 8'h7F);
    op(CMA_DIRECT, 16'h0080, CMA_SP_SFR, 8'h80);
    op(CMA_INDIRECT, 16'h0090, CMA_SP_UPPER);
    op(CMA_BIT, 16'h0021, CMA_SP_IRAM, 8'h0B);
    `CHK(bit_pos, 3'h3)
    op(CMA_BIT, 16'h0088, CMA_SP_SFR, 8'h8A);
    `CHK(bit_pos, 3'h2)
    for (int b = 0; b < 4; b++) begin
      core.ptrs(8'h00, 8'h00, 8'(b << 3), 8'h00, 16'h0000, 16'h0000, 2'h0, 4'h0);
      op(CMA_REGISTER, 16'(7 * b + 7), CMA_SP_IRAM, 8'h00, 3'(7 - b));
    end
    core.issue(CMA_NONE);
    `CHK(illegal, 1'b1)
    `CHK(valid, 1'b0)
    `CHK(space, CMA_SP_NONE)
  endtask : t_data

  // tables, immediates, jumps and vectors
  task automatic t_code();
    core.ptrs(8'h00, 8'h00, 8'h00, 8'h20, 16'hFFF0, 16'h1234, 2'h0, 4'h0);
    op(CMA_INDEX_DATA_POINTER, 16'h0010, CMA_SP_CODE);
    op(CMA_INDEX_PC, 16'h1254, CMA_SP_CODE);
    op(CMA_IMMEDIATE, 16'h1235, CMA_SP_CODE);
    core.issue(CMA_JUMP_INDEX);
    `CHK(fetch, 16'h0010)
    for (int i = 0; i < 3; i++) begin
      core.ptrs(8'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, 2'h0, 4'(i));
      core.issue(CMA_INTERRUPT);
      `CHK(fetch, 16'(3 + 8 * i))
    end
  endtask : t_code

  // paged and 16-bit moves share storage; top page edge and beyond
  task automatic t_expanded_ram();
    core.ptrs(8'h55, 8'hFF, 8'h00, 8'h00, 16'h0155, 16'h0000, 2'h1, 4'h0);
    op(CMA_XMOV_PTR16, 16'h0155, CMA_SP_EXPANDED_RAM, 8'h00, 3'h0, 1'b0, 1'b1, 8'hA5);
    op(CMA_XMOV_PTR8, 16'h0155, CMA_SP_EXPANDED_RAM);
    `CHK(xdata, 8'hA5)
    core.ptrs(8'h55, 8'hFF, 8'h00, 8'h00, 16'h0300, 16'h0000, 2'h2, 4'h0);
    op(CMA_XMOV_PTR8, 16'h02FF, CMA_SP_EXPANDED_RAM, 8'h00, 3'h0, 1'b1, 1'b1, 8'h3C);
    core.issue(CMA_XMOV_PTR16, 8'h00, 3'h0, 1'b0, 1'b1, 8'h5A);
    core.issue(CMA_XMOV_PTR16);
    `CHK(xdata, 8'h00)
    core.ptrs(8'h55, 8'hFF, 8'h00, 8'h00, 16'h02FF, 16'h0000, 2'h2, 4'h0);
    core.issue(CMA_XMOV_PTR16);
    `CHK(xdata, 8'h3C)
  endtask : t_expanded_ram

  // shortest, middle and longest instruction
  task automatic t_timing();
    int lens [3] = '{1, 3, 6};
    foreach (lens[j]) begin
      @(posedge clk_i);
      start <= 1'b1;
      cycles <= 3'(lens[j]);
      @(posedge clk_i);
      start <= 1'b0;
      #1;
      for (int k = 1; k <= 6; k++) begin
        `CHK(done, k == lens[j])
        @(posedge clk_i);
        #1;
      end
    end
  endtask : t_timing

  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    t_reset_push();
    t_data();
    t_code();
    t_expanded_ram();
    t_timing();
    final_report();
  end
endmodule : testbench

`default_nettype wire
